// ---- src/bfrfh_device.sv ----
// fifo pair end: two fifos, flag timing, resets and request handshake
// Summary of operation
// - master reset overrides all other controls, port a included
// - resets act regardless of port enables
// - master keeps both port clocks toggling during reset
// - master reset sets parity select bit high
// - master reset clears other control bits
// - flag reset empties fifo, keeps configuration
// - master reset loads offsets with eight
// - empty flag: set on rise, released after fall
// - almost-empty flag: same set/release timing
// - full flag: same set/release timing
// - flag change may slip one clock edge
// - fifo selected by address bits high
// - acknowledge needs request and direction stable
// - master may ignore ack, use request as enable
// - ack tied to enable writes in acked cycle
`timescale 1ns/1ps
module bfrfh_device
   import bfrfh_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic reset,
   bfrfh_if.device bus,
   output logic [17:0] ctrl_word,
   output logic [9:0] fifo1_level,
   output logic [9:0] fifo2_level
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   logic [2:0] a_ck_s, b_ck_s;
   logic [1:0] mr_s, fr1_s, fr2_s;
   logic [DATA_W-1:0] mem1 [DEPTH];
   logic [DATA_W-1:0] mem2 [DEPTH];
   logic [PW-1:0] wp1_r, rp1_r, wp2_r, rp2_r;
   logic [CW-1:0] cnt1_r, cnt2_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [OFS_W-1:0] ae1_r, af1_r, ae2_r, af2_r;
   logic [35:0] a_dout_r, b_dout_r;
   logic a_oe_r, b_oe_r;
   logic a_cap_req_r, a_cap_dir_r, a_half_r, a_ack_r;
   logic b_cap_req_r, b_cap_dir_r, b_half_r, b_ack_r;
   logic [7:0] flag_int_r, flag_n_r;
   // *****************************************
   // functions
   // *****************************************
   function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c, input logic inc,
      input logic dec);
      cnt_step = c + CW'(inc) - CW'(dec);
   endfunction
   function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic go);
      ptr_step = go ? p + PW'(1) : p;
   endfunction
   function automatic logic held(input logic cap_req, input logic cap_dir, input logic req,
      input logic dir);
      held = cap_req & req & (cap_dir == dir);
   endfunction
   // *****************************************
   // input synchronisers
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         a_ck_s <= 3'h0;
         b_ck_s <= 3'h0;
         mr_s <= 2'h3;
         fr1_s <= 2'h3;
         fr2_s <= 2'h3;
      end
      else
      begin
         a_ck_s <= {a_ck_s[1:0], bus.port_a_clock};
         b_ck_s <= {b_ck_s[1:0], bus.port_b_clock};
         mr_s <= {mr_s[0], bus.master_reset_n};
         fr1_s <= {fr1_s[0], bus.fifo1_flag_reset_n};
         fr2_s <= {fr2_s[0], bus.fifo2_flag_reset_n};
      end
   end
   // *****************************************
   // edges and access decode
   // *****************************************
   wire a_rise = a_ck_s[1] & ~a_ck_s[2];
   wire a_fall = ~a_ck_s[1] & a_ck_s[2];
   wire b_rise = b_ck_s[1] & ~b_ck_s[2];
   wire b_fall = ~b_ck_s[1] & b_ck_s[2];
   // resets ignore enables and win over any access
   wire mr = reset | ~mr_s[1];
   wire clr1 = mr | ~fr1_s[1];
   wire clr2 = mr | ~fr2_s[1];
   wire a_go = a_rise & ~bus.port_a_enable_n & bus.port_a_request;
   wire b_go = b_rise & ~bus.port_b_enable_n & bus.port_b_request;
   wire a_fifo = (bus.port_a_addr == ADDR_FIFO);
   wire b_fifo = bus.port_b_addr0;
   wire full1 = (cnt1_r == DEPTH_C);
   wire full2 = (cnt2_r == DEPTH_C);
   wire empty1 = (cnt1_r == CW'(0));
   wire empty2 = (cnt2_r == CW'(0));
   wire wr1 = a_go & a_fifo & ~bus.port_a_dir_select & ~full1;
   wire rd2 = a_go & a_fifo & bus.port_a_dir_select & ~empty2;
   wire rd1 = b_go & b_fifo & bus.port_b_dir_select & ~empty1;
   wire wr2 = b_go & b_fifo & ~bus.port_b_dir_select & ~full2;
   wire reg_wr = a_go & ~a_fifo & ~bus.port_a_dir_select;
   wire [35:0] a_reg_rd = (bus.port_a_addr == ADDR_CTRL) ? {18'h00000, ctrl_r} :
      (bus.port_a_addr == ADDR_FLAGREG) ? {af2_r[8:0], ae2_r[8:0], af1_r[8:0], ae1_r[8:0]} :
      (bus.port_a_addr == ADDR_AE1) ? {26'h0000000, ae1_r} :
      (bus.port_a_addr == ADDR_AF1) ? {26'h0000000, af1_r} :
      (bus.port_a_addr == ADDR_AE2) ? {26'h0000000, ae2_r} :
      (bus.port_a_addr == ADDR_AF2) ? {26'h0000000, af2_r} : 36'h000000000;
   wire [35:0] d_a = bus.port_a_data;
   // *****************************************
   // configuration registers on port a
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (mr)
      begin
         ctrl_r <= CTRL_RST;
         ae1_r <= OFS_RST;
         af1_r <= OFS_RST;
         ae2_r <= OFS_RST;
         af2_r <= OFS_RST;
      end
      else if (reg_wr)
      begin
         case (bus.port_a_addr)
            ADDR_CTRL: ctrl_r <= d_a[CTRL_W-1:0];
            ADDR_FLAGREG:
            begin
               ae1_r <= {1'b0, d_a[8:0]};
               af1_r <= {1'b0, d_a[17:9]};
               ae2_r <= {1'b0, d_a[26:18]};
               af2_r <= {1'b0, d_a[35:27]};
            end
            ADDR_AE1: ae1_r <= d_a[OFS_W-1:0];
            ADDR_AF1: af1_r <= d_a[OFS_W-1:0];
            ADDR_AE2: ae2_r <= d_a[OFS_W-1:0];
            ADDR_AF2: af2_r <= d_a[OFS_W-1:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end
   // *****************************************
   // fifo storage and pointers
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (wr1)
         mem1[wp1_r] <= d_a;
      if (wr2)
         mem2[wp2_r] <= bus.port_b_data;
   end
   // flag reset only touches its own fifo
   always_ff @(posedge clk)
   begin
      if (clr1)
      begin
         wp1_r <= PW'(0);
         rp1_r <= PW'(0);
         cnt1_r <= CW'(0);
      end
      else
      begin
         wp1_r <= ptr_step(wp1_r, wr1);
         rp1_r <= ptr_step(rp1_r, rd1);
         cnt1_r <= cnt_step(cnt1_r, wr1, rd1);
      end
      if (clr2)
      begin
         wp2_r <= PW'(0);
         rp2_r <= PW'(0);
         cnt2_r <= CW'(0);
      end
      else
      begin
         wp2_r <= ptr_step(wp2_r, wr2);
         rp2_r <= ptr_step(rp2_r, rd2);
         cnt2_r <= cnt_step(cnt2_r, wr2, rd2);
      end
   end
   // *****************************************
   // read data, held until next rise of the port clock
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (mr)
      begin
         a_oe_r <= 1'b0;
         b_oe_r <= 1'b0;
         a_dout_r <= 36'h000000000;
         b_dout_r <= 36'h000000000;
      end
      else
      begin
         if (a_rise)
         begin
            a_oe_r <= a_go & bus.port_a_dir_select;
            a_dout_r <= a_fifo ? mem2[rp2_r] : a_reg_rd;
         end
         if (b_rise)
         begin
            b_oe_r <= b_go & bus.port_b_dir_select;
            b_dout_r <= b_fifo ? mem1[rp1_r] : 36'h000000000;
         end
      end
   end
   // *****************************************
   // request / acknowledge, checked over one full port cycle
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (mr)
      begin
         {a_cap_req_r, a_cap_dir_r, a_half_r, a_ack_r} <= 4'h0;
         {b_cap_req_r, b_cap_dir_r, b_half_r, b_ack_r} <= 4'h0;
      end
      else
      begin
         if (a_fall)
            a_half_r <= held(a_cap_req_r, a_cap_dir_r, bus.port_a_request,
               bus.port_a_dir_select);
         if (a_rise)
         begin
            a_ack_r <= a_half_r & held(a_cap_req_r, a_cap_dir_r, bus.port_a_request,
               bus.port_a_dir_select);
            a_half_r <= 1'b0;
            a_cap_req_r <= bus.port_a_request;
            a_cap_dir_r <= bus.port_a_dir_select;
         end
         if (b_fall)
            b_half_r <= held(b_cap_req_r, b_cap_dir_r, bus.port_b_request,
               bus.port_b_dir_select);
         if (b_rise)
         begin
            b_ack_r <= b_half_r & held(b_cap_req_r, b_cap_dir_r, bus.port_b_request,
               bus.port_b_dir_select);
            b_half_r <= 1'b0;
            b_cap_req_r <= bus.port_b_request;
            b_cap_dir_r <= bus.port_b_dir_select;
         end
      end
   end
   // *****************************************
   // flags: set on a rise, cleared inside on a fall, released on a rise
   // *****************************************
   wire [7:0] cond;
   assign cond[FL_FF1] = full1;
   assign cond[FL_AF1] = (cnt1_r >= DEPTH_C - CW'(af1_r));
   assign cond[FL_EF1] = empty1;
   assign cond[FL_AE1] = (cnt1_r <= CW'(ae1_r));
   assign cond[FL_FF2] = full2;
   assign cond[FL_AF2] = (cnt2_r >= DEPTH_C - CW'(af2_r));
   assign cond[FL_EF2] = empty2;
   assign cond[FL_AE2] = (cnt2_r <= CW'(ae2_r));
   wire [7:0] rise_v = ({8{a_rise}} & FLAG_ON_A) | ({8{b_rise}} & ~FLAG_ON_A);
   wire [7:0] fall_v = ({8{a_fall}} & FLAG_ON_A) | ({8{b_fall}} & ~FLAG_ON_A);
   wire [7:0] clr_v = ({8{clr1}} & FIFO1_FLAGS) | ({8{clr2}} & FIFO2_FLAGS);
   wire [7:0] int_nxt = (flag_int_r | (rise_v & cond)) & ~(fall_v & ~cond);
   wire [7:0] ext_nxt = (flag_n_r & ~(rise_v & cond)) | (rise_v & ~cond & ~flag_int_r);
   // edges seen through the synchroniser, a late fall waits one more cycle
   always_ff @(posedge clk)
   begin
      flag_int_r <= (int_nxt & ~clr_v) | (FLAG_EMPTY_SET & clr_v);
      flag_n_r <= (ext_nxt & ~clr_v) | (~FLAG_EMPTY_SET & clr_v);
   end
   // *****************************************
   // outputs
   // *****************************************
   assign bus.a_dev_d = a_dout_r;
   assign bus.a_dev_oe = a_oe_r;
   assign bus.b_dev_d = b_dout_r;
   assign bus.b_dev_oe = b_oe_r;
   assign bus.port_a_ack = a_ack_r;
   assign bus.port_b_ack = b_ack_r;
   assign bus.flags_n = flag_n_r;
   assign ctrl_word = ctrl_r;
   assign fifo1_level = 10'(cnt1_r);
   assign fifo2_level = 10'(cnt2_r);
endmodule

// ---- include/bfrfh_pkg.sv ----
// shared constants for the two-port bidirectional fifo pair and its master
package bfrfh_pkg;
   localparam int DATA_W = 36;
   localparam int FIFO_DEPTH = 512;
   localparam int CTRL_W = 18;
   localparam int OFS_W = 10;
   localparam int OFS9_W = 9;
   localparam logic [17:0] CTRL_RST = 18'h00001;
   localparam logic [9:0] OFS_RST = 10'h008;
   // port a address map
   localparam logic [2:0] ADDR_FIFO = 3'h7;
   localparam logic [2:0] ADDR_FLAGREG = 3'h5;
   localparam logic [2:0] ADDR_CTRL = 3'h4;
   localparam logic [2:0] ADDR_AE1 = 3'h3;
   localparam logic [2:0] ADDR_AF1 = 3'h2;
   localparam logic [2:0] ADDR_AE2 = 3'h1;
   localparam logic [2:0] ADDR_AF2 = 3'h0;
   // flag vector positions
   localparam int FL_FF1 = 0;
   localparam int FL_AF1 = 1;
   localparam int FL_EF1 = 2;
   localparam int FL_AE1 = 3;
   localparam int FL_FF2 = 4;
   localparam int FL_AF2 = 5;
   localparam int FL_EF2 = 6;
   localparam int FL_AE2 = 7;
   localparam logic [7:0] FLAG_ON_A = 8'hc3;
   localparam logic [7:0] FIFO1_FLAGS = 8'h0f;
   localparam logic [7:0] FIFO2_FLAGS = 8'hf0;
   localparam logic [7:0] FLAG_EMPTY_SET = 8'hcc;
   // host register map and fields
   localparam logic [3:0] HR_CTRL = 4'h0;
   localparam logic [3:0] HR_CMD = 4'h1;
   localparam logic [3:0] HR_WDATA = 4'h2;
   localparam logic [3:0] HR_RDATA = 4'h3;
   localparam logic [3:0] HR_STAT = 4'h4;
   localparam logic [3:0] HR_MASK = 4'h5;
   localparam logic [3:0] HR_FLAGS = 4'h6;
   localparam int HC_MR = 0;
   localparam int HC_FR1 = 1;
   localparam int HC_FR2 = 2;
   localparam int HC_HS = 3;
   localparam int CMD_PORT = 0;
   localparam int CMD_DIR = 1;
   localparam int CMD_ADDR = 2;
   localparam int EV_DONE = 0;
   localparam int EV_FLAG = 1;
   localparam int EV_W = 2;
   // port clock timing
   localparam int CLK_MHZ = 20;
   localparam int PORT_HALF_NS = 200;
   localparam int PORT_HALF_CYC = (PORT_HALF_NS * CLK_MHZ) / 1000;
endpackage

// ---- include/bfrfh_if.sv ----
// pins between the fifo pair and the master that drives both ports
`timescale 1ns/1ps
interface bfrfh_if;
   logic port_a_clock;
   logic port_b_clock;
   logic master_reset_n;
   logic fifo1_flag_reset_n;
   logic fifo2_flag_reset_n;
   logic port_a_dir_select;
   logic port_a_enable_n;
   logic port_a_request;
   logic [2:0] port_a_addr;
   logic [35:0] a_host_d;
   logic a_host_oe;
   logic [35:0] a_dev_d;
   logic a_dev_oe;
   logic [35:0] port_a_data;
   logic port_a_ack;
   logic port_b_dir_select;
   logic port_b_enable_n;
   logic port_b_request;
   logic port_b_addr0;
   logic [35:0] b_host_d;
   logic b_host_oe;
   logic [35:0] b_dev_d;
   logic b_dev_oe;
   logic [35:0] port_b_data;
   logic port_b_ack;
   logic [7:0] flags_n;
   // bus level: whoever enables wins, dev over host on contention
   assign port_a_data = a_dev_oe ? a_dev_d : (a_host_oe ? a_host_d : 36'h000000000);
   assign port_b_data = b_dev_oe ? b_dev_d : (b_host_oe ? b_host_d : 36'h000000000);
   modport device (input port_a_clock, port_b_clock, master_reset_n, fifo1_flag_reset_n,
      fifo2_flag_reset_n, port_a_dir_select, port_a_enable_n, port_a_request, port_a_addr,
      port_a_data, port_b_dir_select, port_b_enable_n, port_b_request, port_b_addr0,
      port_b_data, output a_dev_d, a_dev_oe, b_dev_d, b_dev_oe, port_a_ack, port_b_ack,
      flags_n);
   modport host (output port_a_clock, port_b_clock, master_reset_n, fifo1_flag_reset_n,
      fifo2_flag_reset_n, port_a_dir_select, port_a_enable_n, port_a_request, port_a_addr,
      a_host_d, a_host_oe, port_b_dir_select, port_b_enable_n, port_b_request,
      port_b_addr0, b_host_d, b_host_oe, input port_a_data, port_b_data, port_a_ack,
      port_b_ack, flags_n);
endinterface

// ---- src/bfrfh_host.sv ----
// master end: drives both port clocks and one access at a time from software
`timescale 1ns/1ps
module bfrfh_host
   import bfrfh_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   bfrfh_if.host bus,
   input wire logic [3:0] sw_addr,
   input wire logic [35:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [35:0] sw_rdata,
   output logic irq
);
   typedef enum logic [1:0] {S_IDLE, S_SETUP, S_REQ, S_ACC} bfrfh_hst_e;
   bfrfh_hst_e st_r;
   logic [3:0] div_r;
   logic pclk_r;
   logic [3:0] ctrl_r;
   logic [4:0] cmd_r;
   logic [35:0] wdata_r, rdata_r, sw_rdata_r;
   logic [EV_W-1:0] stat_r, mask_r;
   logic irq_r;
   logic en_n_r, req_r, dir_r, oe_r;
   logic [2:0] addr_r;
   logic [7:0] flags_d_r;
   // *****************************************
   // port clock divider
   // *****************************************
   wire div_end = (div_r == 4'(PORT_HALF_CYC - 1));
   wire tick_fall = div_end & pclk_r;
   // free-running, also while master reset is held
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         div_r <= 4'h0;
         pclk_r <= 1'b0;
      end
      else
      begin
         div_r <= div_end ? 4'h0 : div_r + 4'h1;
         pclk_r <= div_end ? ~pclk_r : pclk_r;
      end
   end
   // *****************************************
   // software port
   // *****************************************
   wire cmd_go = sw_wr & (sw_addr == HR_CMD) & (st_r == S_IDLE);
   wire stat_wr = sw_wr & (sw_addr == HR_STAT);
   wire done_ev = tick_fall & (st_r == S_ACC);
   wire flag_ev = |(flags_d_r & ~bus.flags_n);
   wire [EV_W-1:0] ev = {flag_ev, done_ev};
   wire [EV_W-1:0] stat_nxt = (stat_r & ~(stat_wr ? sw_wdata[EV_W-1:0] : 2'h0)) | ev;
   wire a_sel = ~cmd_r[CMD_PORT];
   wire [35:0] rd_mux = (sw_addr == HR_CTRL) ? {32'h00000000, ctrl_r} :
      (sw_addr == HR_CMD) ? {31'h00000000, cmd_r} :
      (sw_addr == HR_WDATA) ? wdata_r :
      (sw_addr == HR_RDATA) ? rdata_r :
      (sw_addr == HR_STAT) ? {34'h000000000, stat_r} :
      (sw_addr == HR_MASK) ? {34'h000000000, mask_r} :
      (sw_addr == HR_FLAGS) ? {28'h0000000, bus.flags_n} : 36'h000000000;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_r <= 4'h0;
         wdata_r <= 36'h000000000;
         stat_r <= 2'h0;
         mask_r <= 2'h0;
         irq_r <= 1'b0;
         sw_rdata_r <= 36'h000000000;
         flags_d_r <= 8'hff;
      end
      else
      begin
         if (sw_wr & (sw_addr == HR_CTRL))
            ctrl_r <= sw_wdata[3:0];
         if (sw_wr & (sw_addr == HR_WDATA))
            wdata_r <= sw_wdata;
         if (sw_wr & (sw_addr == HR_MASK))
            mask_r <= sw_wdata[EV_W-1:0];
         stat_r <= stat_nxt; // set wins over clear
         irq_r <= |(stat_nxt & mask_r);
         sw_rdata_r <= sw_rd ? rd_mux : 36'h000000000;
         flags_d_r <= bus.flags_n;
      end
   end
   // *****************************************
   // access sequencer, changes pins on port clock falls
   // *****************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_r <= S_IDLE;
         cmd_r <= 5'h00;
         rdata_r <= 36'h000000000;
         en_n_r <= 1'b1;
         req_r <= 1'b0;
         dir_r <= 1'b0;
         oe_r <= 1'b0;
         addr_r <= 3'h0;
      end
      else
      begin
         case (st_r)
            S_IDLE:
            begin
               if (cmd_go)
               begin
                  cmd_r <= sw_wdata[4:0];
                  st_r <= S_SETUP;
               end
            end
            S_SETUP:
            begin
               if (tick_fall)
               begin
                  dir_r <= cmd_r[CMD_DIR];
                  addr_r <= cmd_r[4:CMD_ADDR];
                  oe_r <= ~cmd_r[CMD_DIR];
                  req_r <= 1'b1;
                  // request alone acts as second enable without handshake
                  en_n_r <= ctrl_r[HC_HS];
                  st_r <= ctrl_r[HC_HS] ? S_REQ : S_ACC;
               end
            end
            S_REQ:
            begin
               // acknowledge fed back to enable
               if (tick_fall & (a_sel ? bus.port_a_ack : bus.port_b_ack))
               begin
                  en_n_r <= 1'b0;
                  st_r <= S_ACC;
               end
            end
            S_ACC:
            begin
               if (tick_fall)
               begin
                  en_n_r <= 1'b1;
                  req_r <= 1'b0;
                  oe_r <= 1'b0;
                  if (dir_r)
                     rdata_r <= a_sel ? bus.port_a_data : bus.port_b_data;
                  st_r <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
   // *****************************************
   // pin drive
   // *****************************************
   assign bus.port_a_clock = pclk_r;
   assign bus.port_b_clock = pclk_r;
   assign bus.master_reset_n = ~ctrl_r[HC_MR];
   assign bus.fifo1_flag_reset_n = ~ctrl_r[HC_FR1];
   assign bus.fifo2_flag_reset_n = ~ctrl_r[HC_FR2];
   // fifo selection by address
   assign bus.port_a_addr = addr_r;
   assign bus.port_b_addr0 = addr_r[0];
   assign bus.port_a_dir_select = dir_r;
   assign bus.port_b_dir_select = dir_r;
   assign bus.port_a_enable_n = a_sel ? en_n_r : 1'b1;
   assign bus.port_b_enable_n = a_sel ? 1'b1 : en_n_r;
   assign bus.port_a_request = a_sel & req_r;
   assign bus.port_b_request = ~a_sel & req_r;
   assign bus.a_host_d = wdata_r;
   assign bus.b_host_d = wdata_r;
   assign bus.a_host_oe = a_sel & oe_r;
   assign bus.b_host_oe = ~a_sel & oe_r;
   assign sw_rdata = sw_rdata_r;
   assign irq = irq_r;
endmodule

// ---- tb/bfrfh_monitor.sv ----
// pin-level checks on the link between the fifo pair and its master
`timescale 1ns/1ps
module bfrfh_monitor
   import bfrfh_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic master_reset_n,
   input wire logic fifo1_flag_reset_n,
   input wire logic fifo2_flag_reset_n,
   input wire logic port_a_request,
   input wire logic port_a_ack,
   input wire logic port_b_request,
   input wire logic port_b_ack,
   input wire logic [7:0] flags_n
);
   // ******************
   // checks
   // ******************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // resets held past a full port clock period plus sync delay
   sequence mr_held; !master_reset_n [*8] ##1 !master_reset_n [*6]; endsequence
   sequence fr1_held; !fifo1_flag_reset_n [*8] ##1 !fifo1_flag_reset_n [*6]; endsequence
   sequence fr2_held; !fifo2_flag_reset_n [*8] ##1 !fifo2_flag_reset_n [*6]; endsequence
   mr_empty_a: assert property (
      mr_held |-> flags_n == ~FLAG_EMPTY_SET && !port_a_ack)
      else $error("flags or ack wrong under master reset");
   fr1_empty_a: assert property (fr1_held |-> flags_n[3:0] == 4'h3)
      else $error("fifo1 flags not empty under flag reset");
   fr2_empty_a: assert property (fr2_held |-> flags_n[7:4] == 4'h3)
      else $error("fifo2 flags not empty under flag reset");
   ack_a_req_a: assert property ($rose(port_a_ack) |-> port_a_request)
      else $error("port a ack without request");
   ack_b_req_a: assert property ($rose(port_b_ack) |-> port_b_request)
      else $error("port b ack without request");
   empty_full_a: assert property (
      flags_n[FL_EF1] || flags_n[FL_FF1])
      else $error("fifo1 empty and full at once");
   empty_ae_a: assert property (!flags_n[FL_EF1] || !flags_n[FL_EF2] |->
      (flags_n[FL_EF1] || !flags_n[FL_AE1]) && (flags_n[FL_EF2] || !flags_n[FL_AE2]))
      else $error("empty without almost empty");
   full_af_a: assert property (!flags_n[FL_FF1] |-> !flags_n[FL_AF1])
      else $error("full without almost full");
endmodule

// ---- tb/bfrfh_test.sv ----
// self-checking bench: master end and fifo pair joined, driven from software
`timescale 1ns/1ps
module bfrfh_test
   import bfrfh_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [35:0] sw_wdata = 36'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [35:0] sw_rdata;
   logic irq;
   logic irq_exp = 1'b0;
   logic [17:0] ctrl_word;
   logic [9:0] fifo1_level;
   logic [9:0] fifo2_level;
   logic [35:0] d;
   int n_fail = 0;
   int checks_done = 0;
   bfrfh_if bus_if ();
   // both ends and the pin checker
   bfrfh_host bfrfh_host_inst (.clk(clk), .reset(reset), .bus(bus_if), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
   bfrfh_device bfrfh_device_inst (.clk(clk), .reset(reset), .bus(bus_if),
      .ctrl_word(ctrl_word), .fifo1_level(fifo1_level), .fifo2_level(fifo2_level));
   bfrfh_monitor bfrfh_monitor_inst (.clk(clk), .reset(reset),
      .master_reset_n(bus_if.master_reset_n), .fifo1_flag_reset_n(bus_if.fifo1_flag_reset_n),
      .fifo2_flag_reset_n(bus_if.fifo2_flag_reset_n), .port_a_request(bus_if.port_a_request),
      .port_a_ack(bus_if.port_a_ack), .port_b_request(bus_if.port_b_request),
      .port_b_ack(bus_if.port_b_ack), .flags_n(bus_if.flags_n));
   // ******************
   // helpers
   // ******************
   always #25 clk = ~clk;
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [35:0] exp, input logic [35:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [35:0] v);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // one port access; waits for done, checks irq, clears status
   task automatic op(input logic [2:0] a, input logic rdn, input logic pb, input logic [35:0] v);
      int i;
      wr(HR_WDATA, v);
      wr(HR_CMD, {31'h0, a, rdn, pb});
      for (i = 0; i < 100; i++)
      begin
         rd(HR_STAT);
         if (d[EV_DONE] === 1'b1)
            break;
      end
      if (i == 100)
      begin
         n_fail++;
         test_done();
      end
      @(posedge clk);
      #1 cmp("irq set", {35'h0, irq_exp}, {35'h0, irq});
      repeat (2 * PORT_HALF_CYC) @(posedge clk); // one port period for flags to settle
      wr(HR_STAT, 36'h3);
      @(posedge clk);
      #1 cmp("irq clear", 36'h0, {35'h0, irq});
   endtask
   // hold control bits long enough for both port clocks to edge
   task automatic pulse_ctl(input logic [35:0] v);
      wr(HR_CTRL, v);
      repeat (24) @(posedge clk);
      wr(HR_CTRL, 36'h0);
      repeat (8) @(posedge clk);
   endtask
   // ******************
   // scenarios
   // ******************
   task automatic t_reset();
      int k;
      cmp("ctrl", {18'h0, CTRL_RST}, {18'h0, ctrl_word});
      rd(HR_FLAGS);
      cmp("flags", {28'h0, ~FLAG_EMPTY_SET}, d);
      for (k = 0; k < 4; k++)
      begin
         op(k[2:0], 1'b1, 1'b0, 36'h0);
         rd(HR_RDATA);
         cmp("offset", {26'h0, OFS_RST}, d);
      end
   endtask
   task automatic t_stream();
      int k;
      for (k = 0; k < 9; k++)
      begin
         op(ADDR_FIFO, 1'b0, 1'b0, {4'ha, 22'h0, k[9:0]});
         rd(HR_FLAGS);
         cmp("flags", {28'h0, (k == 8) ? 8'h3f : 8'h37}, d);
      end
      op(3'h6, 1'b0, 1'b0, 36'h1);
      cmp("level1", 36'h9, {26'h0, fifo1_level});
      op(3'h6, 1'b1, 1'b1, 36'h0);
      rd(HR_RDATA);
      cmp("rdata b", 36'h0, d);
      for (k = 0; k < 9; k++)
      begin
         op(ADDR_FIFO, 1'b1, 1'b1, 36'h0);
         rd(HR_RDATA);
         cmp("data b", {4'ha, 22'h0, k[9:0]}, d);
      end
      rd(HR_FLAGS);
      cmp("flags", {28'h0, ~FLAG_EMPTY_SET}, d);
   endtask
   task automatic t_resets();
      op(ADDR_FIFO, 1'b0, 1'b0, 36'h5);
      op(ADDR_FIFO, 1'b0, 1'b1, 36'h6);
      op(ADDR_CTRL, 1'b0, 1'b0, 36'h00100);
      pulse_ctl(36'h6);
      cmp("ctrl kept", 36'h00100, {18'h0, ctrl_word});
      cmp("levels", 36'h0, {16'h0, fifo2_level, fifo1_level});
      pulse_ctl(36'h1);
      cmp("ctrl", {18'h0, CTRL_RST}, {18'h0, ctrl_word});
   endtask
   task automatic t_hs();
      wr(HR_CTRL, 36'h8);
      wr(HR_MASK, 36'h1);
      irq_exp = 1'b1;
      op(ADDR_FIFO, 1'b0, 1'b1, 36'h987654321);
      cmp("level2", 36'h1, {26'h0, fifo2_level});
      op(ADDR_FIFO, 1'b1, 1'b0, 36'h0);
      rd(HR_RDATA);
      cmp("data a", 36'h987654321, d);
      wr(HR_CTRL, 36'h0);
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_stream();
      t_resets();
      t_hs();
      test_done();
   end
endmodule
